// ==== idtc_transfer_ctrl.sv ====
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module idtc_transfer_ctrl #(
  parameter int VEC_COUNT = 256
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Activation from the interrupt controller
  input wire logic I_ACT_REQ,
  input wire logic [7:0] I_ACT_VEC,
  output logic O_ACT_ACK,
  // Shared module-stop control
  input wire logic I_MSTP,
  // Bus master
  output logic O_MEM_REQ,
  output logic O_MEM_WE,
  output logic [1:0] O_MEM_SIZE,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA,
  // Events back to the interrupt controller
  output logic O_CPU_IRQ,
  output logic O_CLR_ENABLE,
  output logic [7:0] O_EVENT_VEC
);
  import idtc_pkg::*;

  // The vector number is 8 bits wide, so the table size is fixed
  if (VEC_COUNT != 256) begin : g_bad_count
    $error("VEC_COUNT must be 256");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic start_reg;
  logic [31:0] vbase_reg;
  logic short_reg;
  logic [1:0] ctrl_reg;
  logic cfg_wr;
  logic active_reg;
  logic [7:0] active_vector_number_reg;

  assign cfg_wr = I_REG_WR && (I_REG_ADDR == OFF_VBASE ||
                  I_REG_ADDR == OFF_ADMOD || I_REG_ADDR == OFF_CTRL);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_reg <= 1'b0;
      vbase_reg <= VBASE_RST;
      short_reg <= 1'b0;
      ctrl_reg <= 2'h0;
    end else if (I_REG_WR) begin
      unique case (I_REG_ADDR)
        OFF_START: start_reg <= I_REG_WDATA[0];
        OFF_VBASE: begin
          // Bases between the two windows are refused, old value kept
          if (&I_REG_WDATA[31:VBASE_CHK_LSB] ||
              ~|I_REG_WDATA[31:VBASE_CHK_LSB]) begin
            vbase_reg <= {I_REG_WDATA[31:VBASE_LSB],
                          {VBASE_LSB{1'b0}}};
          end
        end
        OFF_ADMOD: short_reg <= I_REG_WDATA[0];
        OFF_CTRL: ctrl_reg <= I_REG_WDATA[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        OFF_START: O_REG_RDATA <= {31'h0, start_reg};
        OFF_VBASE: O_REG_RDATA <= vbase_reg;
        OFF_ADMOD: O_REG_RDATA <= {31'h0, short_reg};
        OFF_CTRL: O_REG_RDATA <= {30'h0, ctrl_reg};
        OFF_STATUS: O_REG_RDATA <= {16'h0, active_reg, 7'h00,
                                    active_vector_number_reg};
        default: O_REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_REG_RDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Held record and decode
  // ---------------------------------------------------------------
  idtc_state_t state_reg;
  logic [7:0] mra_reg;
  logic [7:0] mrb_reg;
  logic [31:0] sar_reg;
  logic [31:0] dar_reg;
  logic [15:0] cra_reg;
  logic [15:0] crb_reg;
  logic [31:0] info_addr_reg;
  logic [1:0] idx_reg;
  logic [31:0] data_reg;
  logic hold_valid_reg;
  logic chained_reg;
  logic rec_end_reg;
  logic rec_cnt_end_reg;
  logic irq_pend_reg;
  logic clr_pend_reg;

  logic [1:0] md;
  logic [1:0] sz;
  logic [1:0] sm;
  logic [1:0] dm;
  logic [31:0] rd_word;
  logic [31:0] wb_word;
  logic [1:0] last_idx;
  logic wb_skip;
  logic wb_step;
  logic wrap;
  logic src_area;
  logic [31:0] sar_next;
  logic [31:0] dar_next;
  logic chain_now;
  logic act_ok;

  assign md = mra_reg[MRA_MD_LSB +: 2];
  assign sz = mra_reg[MRA_SZ_LSB +: 2];
  assign sm = mra_reg[MRA_SM_LSB +: 2];
  assign dm = mrb_reg[MRB_DM_LSB +: 2];
  assign src_area = mrb_reg[MRB_DTS_BIT];
  assign last_idx = short_reg ? SHORT_LAST_IDX : FULL_LAST_IDX;
  // Record words follow the byte order of the area that holds them
  assign rd_word = ctrl_reg[CTRL_BIGEND_BIT] ?
                   idtc_swap32(I_MEM_RDATA) : I_MEM_RDATA;
  assign wrap = (md == MD_REPEAT || md == MD_BLOCK) &&
                cra_reg[7:0] == 8'h01;
  assign chain_now = mrb_reg[MRB_CHAIN_ENABLE_BIT] &&
                     (!mrb_reg[MRB_CHNS_BIT] || rec_cnt_end_reg);
  assign act_ok = I_ACT_REQ && start_reg && !I_MSTP;

  always_comb begin
    wb_word = {cra_reg, crb_reg};
    wb_skip = 1'b0;
    if (short_reg) begin
      unique case (idx_reg)
        2'h0: begin
          wb_word = {mra_reg, sar_reg[SHORT_ADDR_W-1:0]};
          wb_skip = !sm[1];
        end
        2'h1: begin
          wb_word = {mrb_reg, dar_reg[SHORT_ADDR_W-1:0]};
          wb_skip = !dm[1];
        end
        default: wb_word = {cra_reg, crb_reg};
      endcase
    end else begin
      unique case (idx_reg)
        2'h0: wb_skip = 1'b1;
        2'h1: begin
          wb_word = sar_reg;
          wb_skip = !sm[1];
        end
        2'h2: begin
          wb_word = dar_reg;
          wb_skip = !dm[1];
        end
        default: wb_word = {cra_reg, crb_reg};
      endcase
    end
    if (ctrl_reg[CTRL_BIGEND_BIT]) begin
      wb_word = idtc_swap32(wb_word);
    end
  end

  assign wb_step = (!O_MEM_REQ && wb_skip) || I_MEM_ACK;

  // Repeat/block area pointer jumps back by the block length on wrap
  idtc_addr_step u_src_step (
    .i_addr(sar_reg),
    .i_mode(sm),
    .i_size(sz),
    .i_reload(wrap && src_area),
    .i_span_cnt(cra_reg[15:8]),
    .o_next(sar_next)
  );

  idtc_addr_step u_dst_step (
    .i_addr(dar_reg),
    .i_mode(dm),
    .i_size(sz),
    .i_reload(wrap && !src_area),
    .i_span_cnt(cra_reg[15:8]),
    .o_next(dar_next)
  );

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_IDLE;
      mra_reg <= 8'h00;
      mrb_reg <= 8'h00;
      sar_reg <= 32'h0000_0000;
      dar_reg <= 32'h0000_0000;
      cra_reg <= 16'h0000;
      crb_reg <= 16'h0000;
      info_addr_reg <= 32'h0000_0000;
      idx_reg <= 2'h0;
      data_reg <= 32'h0000_0000;
      hold_valid_reg <= 1'b0;
      chained_reg <= 1'b0;
      rec_end_reg <= 1'b0;
      rec_cnt_end_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
      active_reg <= 1'b0;
      active_vector_number_reg <= 8'h00;
      O_ACT_ACK <= 1'b0;
      O_MEM_REQ <= 1'b0;
      O_MEM_WE <= 1'b0;
      O_MEM_SIZE <= 2'h0;
      O_MEM_ADDR <= 32'h0000_0000;
      O_MEM_WDATA <= 32'h0000_0000;
      O_CPU_IRQ <= 1'b0;
      O_CLR_ENABLE <= 1'b0;
      O_EVENT_VEC <= 8'h00;
    end else begin
      O_ACT_ACK <= 1'b0;
      O_CPU_IRQ <= 1'b0;
      O_CLR_ENABLE <= 1'b0;
      if (I_MEM_ACK) begin
        O_MEM_REQ <= 1'b0;
      end
      if (cfg_wr) begin
        hold_valid_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: begin
          // Later requests stay pending outside until ack
          if (act_ok) begin
            O_ACT_ACK <= 1'b1;
            active_reg <= 1'b1;
            active_vector_number_reg <= I_ACT_VEC;
            chained_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
            clr_pend_reg <= 1'b0;
            if (ctrl_reg[CTRL_SKIP_BIT] && hold_valid_reg && !cfg_wr &&
                I_ACT_VEC == active_vector_number_reg) begin
              state_reg <= ST_RD;
            end else begin
              hold_valid_reg <= 1'b0;
              state_reg <= ST_VEC;
            end
          end
        end
        ST_VEC: begin
          if (!O_MEM_REQ) begin
            O_MEM_REQ <= 1'b1;
            O_MEM_WE <= 1'b0;
            O_MEM_SIZE <= SZ_LONG;
            O_MEM_ADDR <= vbase_reg + {22'h0, active_vector_number_reg, 2'b00};
          end else if (I_MEM_ACK) begin
            info_addr_reg <= rd_word;
            idx_reg <= 2'h0;
            state_reg <= ST_INFO;
          end
        end
        ST_INFO: begin
          if (!O_MEM_REQ) begin
            O_MEM_REQ <= 1'b1;
            O_MEM_WE <= 1'b0;
            O_MEM_SIZE <= SZ_LONG;
            O_MEM_ADDR <= info_addr_reg + {28'h0, idx_reg, 2'b00};
          end else if (I_MEM_ACK) begin
            if (short_reg) begin
              unique case (idx_reg)
                2'h0: begin
                  mra_reg <= rd_word[31:24];
                  sar_reg <= {{8{rd_word[23]}}, rd_word[23:0]};
                end
                2'h1: begin
                  mrb_reg <= rd_word[31:24];
                  dar_reg <= {{8{rd_word[23]}}, rd_word[23:0]};
                end
                default: {cra_reg, crb_reg} <= rd_word;
              endcase
            end else begin
              unique case (idx_reg)
                2'h0: {mra_reg, mrb_reg} <= rd_word[31:16];
                2'h1: sar_reg <= rd_word;
                2'h2: dar_reg <= rd_word;
                default: {cra_reg, crb_reg} <= rd_word;
              endcase
            end
            if (idx_reg == last_idx) begin
              state_reg <= ST_RD;
            end else begin
              idx_reg <= idx_reg + 2'h1;
            end
          end
        end
        ST_RD: begin
          if (!O_MEM_REQ) begin
            O_MEM_REQ <= 1'b1;
            O_MEM_WE <= 1'b0;
            O_MEM_SIZE <= sz;
            O_MEM_ADDR <= sar_reg;
          end else if (I_MEM_ACK) begin
            data_reg <= I_MEM_RDATA;
            state_reg <= ST_WR;
          end
        end
        ST_WR: begin
          if (!O_MEM_REQ) begin
            O_MEM_REQ <= 1'b1;
            O_MEM_WE <= 1'b1;
            O_MEM_SIZE <= sz;
            O_MEM_ADDR <= dar_reg;
            O_MEM_WDATA <= data_reg;
          end else if (I_MEM_ACK) begin
            sar_reg <= sar_next;
            dar_reg <= dar_next;
            rec_end_reg <= 1'b0;
            rec_cnt_end_reg <= 1'b0;
            idx_reg <= 2'h0;
            state_reg <= ST_WB;
            unique case (md)
              MD_NORMAL: begin
                cra_reg <= cra_reg - 16'h0001;
                rec_end_reg <= (cra_reg == 16'h0001);
                rec_cnt_end_reg <= (cra_reg == 16'h0001);
              end
              MD_BLOCK: begin
                if (wrap) begin
                  cra_reg[7:0] <= cra_reg[15:8];
                  crb_reg <= crb_reg - 16'h0001;
                  rec_end_reg <= (crb_reg == 16'h0001);
                  rec_cnt_end_reg <= (crb_reg == 16'h0001);
                end else begin
                  cra_reg[7:0] <= cra_reg[7:0] - 8'h01;
                  state_reg <= ST_RD;
                end
              end
              default: begin
                // Repeat never ends on its own; the wrap is its count end
                cra_reg[7:0] <= wrap ? cra_reg[15:8] :
                                cra_reg[7:0] - 8'h01;
                rec_cnt_end_reg <= wrap;
              end
            endcase
          end
        end
        ST_WB: begin
          if (!O_MEM_REQ && !wb_skip) begin
            O_MEM_REQ <= 1'b1;
            O_MEM_WE <= 1'b1;
            O_MEM_SIZE <= SZ_LONG;
            O_MEM_ADDR <= info_addr_reg + {28'h0, idx_reg, 2'b00};
            O_MEM_WDATA <= wb_word;
          end else if (wb_step) begin
            if (idx_reg != last_idx) begin
              idx_reg <= idx_reg + 2'h1;
            end else begin
              if (mrb_reg[MRB_CPU_IRQ_SELECT_BIT] || rec_end_reg) begin
                irq_pend_reg <= 1'b1;
              end
              if (rec_end_reg && !chain_now) begin
                clr_pend_reg <= 1'b1;
              end
              if (chain_now) begin
                chained_reg <= 1'b1;
                idx_reg <= 2'h0;
                info_addr_reg <= info_addr_reg + (short_reg ?
                                 SHORT_REC_BYTES : FULL_REC_BYTES);
                state_reg <= ST_INFO;
              end else begin
                state_reg <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          O_CPU_IRQ <= irq_pend_reg;
          O_CLR_ENABLE <= clr_pend_reg;
          O_EVENT_VEC <= active_vector_number_reg;
          // A chained pass leaves the last record in hand, not the first
          hold_valid_reg <= ctrl_reg[CTRL_SKIP_BIT] && !chained_reg &&
                            !cfg_wr;
          active_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== idtc_pkg.sv ====
package idtc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_VBASE = 8'h04;
  localparam logic [7:0] OFF_ADMOD = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int VBASE_LSB = 12;
  localparam int VBASE_CHK_LSB = 27;
  localparam int CTRL_SKIP_BIT = 0;
  localparam int CTRL_BIGEND_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 15;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Mode word fields
  // ---------------------------------------------------------------
  localparam int MRA_MD_LSB = 6;
  localparam int MRA_SZ_LSB = 4;
  localparam int MRA_SM_LSB = 2;
  localparam int MRB_CHAIN_ENABLE_BIT = 7;
  localparam int MRB_CHNS_BIT = 6;
  localparam int MRB_CPU_IRQ_SELECT_BIT = 5;
  localparam int MRB_DTS_BIT = 4;
  localparam int MRB_DM_LSB = 2;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // ---------------------------------------------------------------
  // Record layout
  // ---------------------------------------------------------------
  localparam logic [1:0] FULL_LAST_IDX = 2'h3;
  localparam logic [1:0] SHORT_LAST_IDX = 2'h2;
  localparam logic [31:0] FULL_REC_BYTES = 32'h0000_0010;
  localparam logic [31:0] SHORT_REC_BYTES = 32'h0000_000C;
  localparam int SHORT_ADDR_W = 24;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_VEC = 7'h02,
    ST_INFO = 7'h04,
    ST_RD = 7'h08,
    ST_WR = 7'h10,
    ST_WB = 7'h20,
    ST_DONE = 7'h40
  } idtc_state_t;

  function automatic logic [31:0] idtc_swap32(input logic [31:0] w);
    idtc_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

endpackage

// ==== idtc_addr_step.sv ====
`timescale 1ns/1ps
`default_nettype none
module idtc_addr_step (
  // Current pointer and its update mode
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_size,
  // Return to the area start after this unit
  input wire logic i_reload,
  input wire logic [7:0] i_span_cnt,
  // Result
  output logic [31:0] o_next
);
  import idtc_pkg::*;

  logic [31:0] unit;
  logic [31:0] span;
  logic [8:0] cnt;

  always_comb begin
    unit = (i_size == SZ_LONG || i_size[1]) ? 32'h0000_0004 :
           (32'h0000_0001 << i_size);
    // A zero count stands for the full 256 units
    cnt = (i_span_cnt == 8'h00) ? 9'h100 : {1'b0, i_span_cnt};
    span = {23'h000000, cnt} * unit;
    unique case (i_mode)
      AM_INC: o_next = i_reload ? i_addr + unit - span : i_addr + unit;
      AM_DEC: o_next = i_reload ? i_addr - unit + span : i_addr - unit;
      default: o_next = i_addr;
    endcase
  end
endmodule
`default_nettype wire

// ==== idtc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module idtc_properties
  import idtc_pkg::*;
#(
  parameter int VEC_COUNT = 256
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [31:0] O_REG_RDATA,
  // Activation
  input wire logic I_ACT_REQ,
  input wire logic [7:0] I_ACT_VEC,
  input wire logic O_ACT_ACK,
  input wire logic I_MSTP,
  // Bus master and events
  input wire logic O_MEM_REQ,
  input wire logic O_MEM_WE,
  input wire logic [1:0] O_MEM_SIZE,
  input wire logic [31:0] O_MEM_ADDR,
  input wire logic I_MEM_ACK,
  input wire logic O_CPU_IRQ,
  input wire logic O_CLR_ENABLE
);
  logic start_q;
  logic skip_q;
  logic [19:0] vbase_q;
  logic [7:0] vec_q;
  // Shadow of the settings that the properties depend on
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_q <= 1'b0;
      skip_q <= 1'b0;
      vbase_q <= 20'h0;
      vec_q <= 8'h0;
    end else begin
      if (I_REG_WR && I_REG_ADDR == OFF_START) start_q <= I_REG_WDATA[0];
      if (I_REG_WR && I_REG_ADDR == OFF_CTRL) skip_q <= I_REG_WDATA[0];
      if (I_REG_WR && I_REG_ADDR == OFF_VBASE &&
          (&I_REG_WDATA[31:27] || ~|I_REG_WDATA[31:27]))
        vbase_q <= I_REG_WDATA[31:12];
      if (O_ACT_ACK) vec_q <= I_ACT_VEC;
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  chk_take_gated: assert property (O_ACT_ACK |->
    $past(I_ACT_REQ) && $past(start_q) && !$past(I_MSTP))
    else $error("ack without enabled request");
  chk_one_busy: assert property (O_ACT_ACK |=> (!O_ACT_ACK) [*5])
    else $error("second ack during transfer");
  chk_req_steady: assert property (O_MEM_REQ && !I_MEM_ACK |=>
    O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WE) &&
    $stable(O_MEM_SIZE))
    else $error("bus request changed before ack");
  chk_req_release: assert property (O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
    else $error("bus request held after ack");
  chk_vector_fetch: assert property (
    $rose(O_MEM_REQ) && $past(O_ACT_ACK) && !skip_q |-> !O_MEM_WE &&
    O_MEM_ADDR == ({vbase_q, 12'h000} + {22'h0, vec_q, 2'b00}))
    else $error("vector entry address wrong");
  chk_status_vec: assert property (
    $past(I_REG_RD) && $past(I_REG_ADDR) == OFF_STATUS |->
    O_REG_RDATA[7:0] == vec_q && O_REG_RDATA[14:8] == 7'h00)
    else $error("status vector field wrong");
  chk_rdata_quiet: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 0)
    else $error("read data outside read slot");
  chk_clear_irq: assert property (O_CLR_ENABLE |-> O_CPU_IRQ)
    else $error("enable cleared without cpu interrupt");
endmodule

bind idtc_transfer_ctrl idtc_properties #(.VEC_COUNT(VEC_COUNT)) u_props (
  .I_SYS_CLK, .I_RST_N, .I_REG_ADDR, .I_REG_WDATA, .I_REG_WR, .I_REG_RD,
  .O_REG_RDATA, .I_ACT_REQ, .I_ACT_VEC, .O_ACT_ACK, .I_MSTP, .O_MEM_REQ,
  .O_MEM_WE, .O_MEM_SIZE, .O_MEM_ADDR, .I_MEM_ACK, .O_CPU_IRQ, .O_CLR_ENABLE);
`default_nettype wire

// ==== idtc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module idtc_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request from the controller
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  // Answer
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:1023];
  logic [1:0] wait_cnt;
  // Whole-word store only: the size is ignored, so the bench's byte units also move whole words.
  // Read data toggles outside the ack cycle so stale values never pass.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      wait_cnt <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (!i_slow || wait_cnt == 2'h3) begin
          o_ack <= 1'b1;
          wait_cnt <= 2'h0;
          if (i_we) mem[i_addr[11:2]] <= i_wdata;
          else o_rdata <= mem[i_addr[11:2]];
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_interrupt_driven_transfer_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_interrupt_driven_transfer_ctrl;
  import idtc_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, act_req, mstp, slow;
  logic ack, mem_req, mem_we, mem_ack, irq, clr;
  logic [7:0] reg_addr, act_vec, ev_vec;
  logic [31:0] reg_wdata, rdata, mem_rdata, mem_addr, mem_wdata, last_rd;
  logic [1:0] mem_size, last_size;
  int mismatches, n_checks, n_irq, n_clr, n_ack;

  idtc_transfer_ctrl #(.VEC_COUNT(256)) dut (.I_SYS_CLK(sys_clk),
    .I_RST_N(rst_n), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata),
    .I_ACT_REQ(act_req), .I_ACT_VEC(act_vec), .O_ACT_ACK(ack),
    .I_MSTP(mstp), .O_MEM_REQ(mem_req), .O_MEM_WE(mem_we),
    .O_MEM_SIZE(mem_size), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
    .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata), .O_CPU_IRQ(irq),
    .O_CLR_ENABLE(clr), .O_EVENT_VEC(ev_vec));
  idtc_mem_model mem_u (.i_clk(sys_clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr), .i_wdata(mem_wdata),
    .o_ack(mem_ack), .o_rdata(mem_rdata));

  always @(posedge sys_clk) begin
    if (ack === 1'b1) n_ack++;
    if (irq === 1'b1) n_irq++;
    if (clr === 1'b1) n_clr++;
    if (mem_req && mem_ack && !mem_we) begin
      last_rd = mem_addr;
      last_size = mem_size;
    end
  end

  // ----------
  // Bus tasks
  // ----------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // act is only called for vectors whose records are set up; t_stop raises vector 05 before its record exists
  task automatic act(input logic [7:0] v);
    logic [31:0] s;
    int k;
    @(posedge sys_clk);
    act_req <= 1'b1;
    act_vec <= v;
    k = 0;
    do begin @(posedge sys_clk); #1; k++; end while (ack !== 1'b1 && k < 40);
    `CHK(ack, 1'b1)
    @(posedge sys_clk);
    act_req <= 1'b0;
    rd(OFF_STATUS, s);
    `CHK(s[STAT_ACTIVE_BIT], 1'b1)
    k = 0;
    while (s[STAT_ACTIVE_BIT] !== 1'b0 && k < 60) begin
      rd(OFF_STATUS, s);
      k++;
    end
    `CHK(s[15:0], {8'h00, v})
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    logic [31:0] d;
    logic [31:0] w[3] = '{32'hF800_0ABC, 32'h1234_5678, 32'h07FF_F123};
    logic [31:0] e[3] = '{32'hF800_0000, 32'hF800_0000, 32'h07FF_F000};
    for (int a = 0; a <= 'h20; a += 4) begin
      rd(8'(a), d);
      `CHK(d, 32'h0)
    end
    for (int i = 0; i < 3; i++) begin
      wr(OFF_VBASE, w[i]);
      rd(OFF_VBASE, d);
      `CHK(d, e[i])
    end
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rd(OFF_STATUS, d);
    `CHK(d, 32'h0)
    wr(OFF_VBASE, 32'h0);
  endtask
  task automatic t_stop();
    @(posedge sys_clk);
    act_req <= 1'b1;
    act_vec <= 8'h05;
    // Start bit still clear from reset: the request must wait
    repeat (12) @(posedge sys_clk);
    `CHK(n_ack, 0)
    mstp <= 1'b1;
    wr(OFF_START, 32'h1);
    repeat (12) @(posedge sys_clk);
    `CHK(n_ack, 0)
    act_req <= 1'b0;
    mstp <= 1'b0;
  endtask
  task automatic t_normal();
    int i0, c0;
    mem_u.mem[5] = 32'h100;
    mem_u.mem['h40] = 32'h2808_0000;
    mem_u.mem['h41] = 32'h200;
    mem_u.mem['h42] = 32'h300;
    mem_u.mem['h43] = 32'h0002_0000;
    mem_u.mem['h80] = 32'hA1A1_0001;
    mem_u.mem['h81] = 32'hA2A2_0002;
    i0 = n_irq;
    c0 = n_clr;
    act(8'h05);
    `CHK(mem_u.mem['hC0], 32'hA1A1_0001)
    `CHK(mem_u.mem['h41], 32'h204)
    `CHK(mem_u.mem['h42], 32'h304)
    `CHK(mem_u.mem['h43], 32'h0001_0000)
    `CHK(n_irq - i0, 0)
    `CHK(last_size, SZ_LONG)
    @(posedge sys_clk);
    slow <= 1'b1;
    act(8'h05);
    `CHK(mem_u.mem['hC1], 32'hA2A2_0002)
    `CHK(n_irq - i0, 1)
    `CHK(n_clr - c0, 1)
    `CHK(ev_vec, 8'h05)
  endtask
  task automatic t_repeat();
    int i0, c0;
    mem_u.mem[6] = 32'h140;
    mem_u.mem['h50] = 32'h6810_0000;
    mem_u.mem['h51] = 32'h200;
    mem_u.mem['h52] = 32'h310;
    mem_u.mem['h53] = 32'h0202_0000;
    wr(OFF_CTRL, 32'h1);
    i0 = n_irq;
    c0 = n_clr;
    act(8'h06);
    `CHK(last_rd, 32'h200)
    mem_u.mem['h51] = 32'h280;
    act(8'h06);
    `CHK(last_rd, 32'h204)
    `CHK(mem_u.mem['hC4], 32'hA2A2_0002)
    `CHK(mem_u.mem['h51], 32'h200)
    `CHK(mem_u.mem['h53], 32'h0202_0000)
    act(8'h06);
    `CHK(last_rd, 32'h200)
    `CHK(n_irq - i0 + n_clr - c0, 0)
  endtask
  task automatic t_block();
    int i0, c0;
    mem_u.mem[7] = 32'h180;
    mem_u.mem['h60] = 32'hA838_0000;
    mem_u.mem['h61] = 32'h200;
    mem_u.mem['h62] = 32'h320;
    mem_u.mem['h63] = 32'h0202_0002;
    mem_u.mem['hCA] = 32'h0;
    i0 = n_irq;
    c0 = n_clr;
    act(8'h07);
    `CHK(mem_u.mem['hC9], 32'hA2A2_0002)
    `CHK(mem_u.mem['hCA], 32'h0)
    `CHK(mem_u.mem['h62], 32'h328)
    `CHK(mem_u.mem['h63][15:0], 16'h0001)
    `CHK(n_irq - i0, 1)
    `CHK(n_clr - c0, 0)
    act(8'h07);
    `CHK(n_clr - c0, 1)
  endtask
  task automatic t_short();
    int c0;
    wr(OFF_ADMOD, 32'h1);
    mem_u.mem[8] = 32'h1C0;
    mem_u.mem['h70] = 32'h28FF_F800;
    mem_u.mem['h71] = 32'h0800_0340;
    mem_u.mem['h72] = 32'h0001_0000;
    mem_u.mem['h200] = 32'h5A5A_A5A5;
    c0 = n_clr;
    act(8'h08);
    `CHK(last_rd, 32'hFFFF_F800)
    `CHK(mem_u.mem['hD0], 32'h5A5A_A5A5)
    `CHK(n_clr - c0, 1)
  endtask
  task automatic t_chain();
    int i0, c0;
    wr(OFF_CTRL, 32'h2);
    // Big-endian records: every record and vector word is byte-swapped
    mem_u.mem[9] = 32'h4002_0000;
    mem_u.mem['h90] = 32'h0002_0020;
    mem_u.mem['h91] = 32'h5003_00C0;
    mem_u.mem['h92] = 32'h0000_0100;
    mem_u.mem['h93] = 32'h0402_0000;
    mem_u.mem['h94] = 32'h5403_0000;
    mem_u.mem['h95] = 32'h0000_0200;
    i0 = n_irq;
    c0 = n_clr;
    act(8'h09);
    `CHK(mem_u.mem['hD4], 32'hA1A1_0001)
    `CHK(mem_u.mem['hD5], 32'hA2A2_0002)
    `CHK(last_size, 2'h0)
    `CHK(mem_u.mem['h95], 32'h0000_0100)
    `CHK(n_irq - i0 + n_clr - c0, 1)
    // First record no longer ends its count, so no chaining
    mem_u.mem['hD5] = 32'h0;
    act(8'h09);
    `CHK(mem_u.mem['hD5], 32'h0)
    `CHK(mem_u.mem['h92], 32'h0000_FFFF)
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, act_req, mstp, slow} = 5'h0;
    {reg_addr, act_vec, reg_wdata} = 48'h0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_stop();
    t_normal();
    t_repeat();
    t_block();
    t_short();
    t_chain();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
